// *** pgrw_top.sv ***
// graphics controller read/write datapath with index/data register port
// assumes host I/O and memory strobes are synchronous one-cycle pulses
`timescale 1ns/1ps
`include "pgrw_defines.svh"
// Overview of operation
// - mode 0 enabled maps get their set/reset bit on all eight bits
// - mode 0 enable one gives set/reset, zero gives host data
// - compare read returns one where all four maps match compare value
// - function field: pass, AND, OR, XOR with latch contents
// - rotation happens before the logic operation
// - mode 0 right-rotates host byte by the rotate count
// - normal read returns the map named by the plane field
// - 256-colour bit overrides interleave for shift loading
// - interleave bit selects even/odd bit shift loading
// - mode bit four selects odd/even addressing
// - read type picks compare or map; chain-four ignores plane field
// - mode 1 writes each map with its latch byte
// - mode 2 fills map n with host data bit n
// - mode 3 writes set/reset, mask is rotated data and bit mask
// - logic op applies in modes 0, 2, 3, not mode 1
// - low four index bits pick the register, upper bits reserved
// - bit mask one writes the bit, zero keeps the latch
module pgrw_top
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // host i/o port
    input wire logic ioWrIndex,
    input wire logic ioWrData,
    input wire logic ioRdIndex,
    input wire logic ioRdData,
    input wire logic [7:0] ioWdata,
    output logic [7:0] ioRdata_q,
    // host memory cycle
    input wire logic memWr,
    input wire logic memRd,
    input wire logic [1:0] memAddrLow,
    input wire logic [7:0] memWdata,
    output logic [7:0] memRdata_q,
    // plane memory side
    input wire logic [31:0] planeRdata,
    output logic [31:0] planeWdata_q,
    output logic planeWrite_q,
    // chain-four from the sequencer
    input wire logic chain4,
    // shift loading and addressing mode
    output logic shiftColor256_q,
    output logic shiftInterleave_q,
    output logic oddEvenAddr_q
);
    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    logic rstSync1_q;
    logic rstSync2_q;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end
        else
        begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    wire logic rstN = rstSync2_q;
    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [3:0] index_q;
    logic [7:0] srValue_q;
    logic [7:0] srEnable_q;
    logic [7:0] cmpValue_q;
    logic [7:0] rotLogic_q;
    logic [7:0] readPlane_q;
    logic [7:0] mode_q;
    logic [7:0] bitMask_q;
    // only the low nibble is kept; upper index bits read zero
    wire logic [7:0] indexRead = {4'h0, index_q};
    wire logic selSr = (index_q == `PGRW_IDX_SR_VALUE);
    wire logic selEn = (index_q == `PGRW_IDX_SR_ENABLE);
    wire logic selCmp = (index_q == `PGRW_IDX_CMP_VALUE);
    wire logic selRot = (index_q == `PGRW_IDX_ROT_LOGIC);
    wire logic selPl = (index_q == `PGRW_IDX_READ_PLANE);
    wire logic selMode = (index_q == `PGRW_IDX_MODE);
    wire logic selMask = (index_q == `PGRW_IDX_BIT_MASK);
    // unmapped indices read zero and ignore writes
    wire logic [7:0] dataRead =
        selSr ? srValue_q :
        selEn ? srEnable_q :
        selCmp ? cmpValue_q :
        selRot ? rotLogic_q :
        selPl ? readPlane_q :
        selMode ? mode_q :
        selMask ? bitMask_q : 8'h00;
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
            index_q <= 4'h0;
        else if (ioWrIndex)
            index_q <= ioWdata[3:0];
    end
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            srValue_q <= `PGRW_RST_REG;
            srEnable_q <= `PGRW_RST_REG;
            cmpValue_q <= `PGRW_RST_REG;
            rotLogic_q <= `PGRW_RST_REG;
            readPlane_q <= `PGRW_RST_REG;
            mode_q <= `PGRW_RST_REG;
            bitMask_q <= `PGRW_RST_MASK;
        end
        else if (ioWrData)
        begin
            // data port lands in whichever register the index names
            if (selSr) srValue_q <= ioWdata & `PGRW_MASK_LOW4;
            if (selEn) srEnable_q <= ioWdata & `PGRW_MASK_LOW4;
            if (selCmp) cmpValue_q <= ioWdata & `PGRW_MASK_LOW4;
            if (selRot) rotLogic_q <= ioWdata & `PGRW_MASK_ROT;
            if (selPl) readPlane_q <= ioWdata & `PGRW_MASK_PLANE;
            if (selMode) mode_q <= ioWdata & `PGRW_MASK_MODE;
            if (selMask) bitMask_q <= ioWdata;
        end
    end
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
            ioRdata_q <= 8'h00;
        else if (ioRdIndex)
            ioRdata_q <= indexRead;
        else if (ioRdData)
            ioRdata_q <= dataRead;
    end
    // ----------------------------------------
    // configuration fan-out
    // ----------------------------------------
    pgrw_cfg_if cfg ();
    assign cfg.srValue = srValue_q[3:0];
    assign cfg.srEnable = srEnable_q[3:0];
    assign cfg.cmpValue = cmpValue_q[3:0];
    assign cfg.rotCount = rotLogic_q[`PGRW_ROT_LSB +: 3];
    assign cfg.func = pgrw_pkg::pgrw_func_e'(rotLogic_q[`PGRW_FUNC_LSB +: 2]);
    assign cfg.wmode = pgrw_pkg::pgrw_wmode_e'(mode_q[`PGRW_MODE_WM_LSB +: 2]);
    assign cfg.bitMask = bitMask_q;
    // ----------------------------------------
    // latches and datapaths
    // ----------------------------------------
    logic [31:0] latch_q;
    logic [31:0] wrNext;
    logic [7:0] rdNext;
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
            latch_q <= 32'h0000_0000;
        else if (memRd)
            latch_q <= planeRdata;
    end
    pgrw_write_path u_write
    (
        .cfg(cfg),
        .hostData(memWdata),
        .latches(latch_q),
        .planeOut(wrNext)
    );
    // reads answer from the live planes so the answer and latch agree
    pgrw_read_path u_read
    (
        .cfg(cfg),
        .readType(mode_q[`PGRW_MODE_READTYPE]),
        .chain4(chain4),
        .planeSel(readPlane_q[1:0]),
        .addrLow(memAddrLow),
        .planes(planeRdata),
        .readData(rdNext)
    );
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            memRdata_q <= 8'h00;
            planeWdata_q <= 32'h0000_0000;
            planeWrite_q <= 1'b0;
        end
        else
        begin
            if (memRd)
                memRdata_q <= rdNext;
            if (memWr)
                planeWdata_q <= wrNext;
            planeWrite_q <= memWr;
        end
    end
    // ----------------------------------------
    // shift loading and addressing mode
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            shiftColor256_q <= 1'b0;
            shiftInterleave_q <= 1'b0;
            oddEvenAddr_q <= 1'b0;
        end
        else
        begin
            shiftColor256_q <= mode_q[`PGRW_MODE_COLOR256];
            // 256-colour loading wins over interleave
            shiftInterleave_q <= mode_q[`PGRW_MODE_INTERLEAVE] &
                ~mode_q[`PGRW_MODE_COLOR256];
            oddEvenAddr_q <= mode_q[`PGRW_MODE_ODDEVEN];
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_latch_load;
        @(posedge ref_clk) disable iff (!rstN)
        memRd |=> (latch_q == $past(planeRdata));
    endproperty
    a_latch_load: assert property (p_latch_load)
        else $error("latches not loaded on read");
    property p_mode1;
        @(posedge ref_clk) disable iff (!rstN)
        (memWr && cfg.wmode == pgrw_pkg::PGRW_WM_LATCH)
            |=> (planeWdata_q == $past(latch_q)) && planeWrite_q;
    endproperty
    a_mode1: assert property (p_mode1)
        else $error("mode 1 write is not latch data");
    property p_mode3_sr;
        @(posedge ref_clk) disable iff (!rstN)
        (memWr && cfg.wmode == pgrw_pkg::PGRW_WM_MASKED &&
            cfg.func == pgrw_pkg::PGRW_FN_PASS && bitMask_q == 8'hff &&
            cfg.rotCount == 3'h0 && memWdata == 8'hff)
            |=> (planeWdata_q[7:0] == {8{$past(srValue_q[0])}});
    endproperty
    a_mode3_sr: assert property (p_mode3_sr)
        else $error("mode 3 plane 0 not set/reset value");
    property p_mode2;
        @(posedge ref_clk) disable iff (!rstN)
        (memWr && cfg.wmode == pgrw_pkg::PGRW_WM_SPREAD &&
            cfg.func == pgrw_pkg::PGRW_FN_PASS && bitMask_q == 8'hff)
            |=> (planeWdata_q[31:24] == {8{$past(memWdata[3])}});
    endproperty
    a_mode2: assert property (p_mode2)
        else $error("mode 2 plane 3 not spread");
    property p_rot;
        @(posedge ref_clk) disable iff (!rstN)
        (memWr && cfg.wmode == pgrw_pkg::PGRW_WM_SUBST &&
            cfg.srEnable[1] == 1'b0 && cfg.rotCount == 3'h1 &&
            cfg.func == pgrw_pkg::PGRW_FN_PASS && bitMask_q == 8'hff)
            |=> (planeWdata_q[15:8] ==
                {$past(memWdata[0]), $past(memWdata[7:1])});
    endproperty
    a_rot: assert property (p_rot)
        else $error("rotate by one wrong");
    property p_xor;
        @(posedge ref_clk) disable iff (!rstN)
        (memWr && cfg.wmode == pgrw_pkg::PGRW_WM_SUBST &&
            cfg.srEnable[2] == 1'b1 && cfg.func == pgrw_pkg::PGRW_FN_XOR &&
            bitMask_q == 8'hff)
            |=> (planeWdata_q[23:16] ==
                ({8{$past(srValue_q[2])}} ^ $past(latch_q[23:16])));
    endproperty
    a_xor: assert property (p_xor)
        else $error("xor with latch wrong");
    property p_mask0;
        @(posedge ref_clk) disable iff (!rstN)
        (memWr && cfg.wmode == pgrw_pkg::PGRW_WM_SUBST && bitMask_q == 8'h00)
            |=> (planeWdata_q == $past(latch_q));
    endproperty
    a_mask0: assert property (p_mask0)
        else $error("zero mask changed data");
    property p_cmp;
        @(posedge ref_clk) disable iff (!rstN)
        (memRd && mode_q[`PGRW_MODE_READTYPE] && cmpValue_q[3:0] == 4'h0)
            |=> (memRdata_q == ~($past(planeRdata[7:0]) |
                $past(planeRdata[15:8]) | $past(planeRdata[23:16]) |
                $past(planeRdata[31:24])));
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare read wrong");
    property p_sel;
        @(posedge ref_clk) disable iff (!rstN)
        (memRd && !mode_q[`PGRW_MODE_READTYPE] && !chain4 &&
            readPlane_q[1:0] == 2'h2)
            |=> (memRdata_q == $past(planeRdata[23:16]));
    endproperty
    a_sel: assert property (p_sel)
        else $error("plane select read wrong");
    property p_il;
        @(posedge ref_clk) disable iff (!rstN)
        shiftColor256_q |-> !shiftInterleave_q;
    endproperty
    a_il: assert property (p_il)
        else $error("interleave active with 256-colour");
    property p_oddeven;
        @(posedge ref_clk) disable iff (!rstN)
        1'b1 |=> (oddEvenAddr_q == $past(mode_q[`PGRW_MODE_ODDEVEN]));
    endproperty
    a_oddeven: assert property (p_oddeven)
        else $error("odd/even addressing bit wrong");
    property p_index_rd;
        @(posedge ref_clk) disable iff (!rstN)
        ioRdIndex |=> (ioRdata_q == {4'h0, $past(index_q)});
    endproperty
    a_index_rd: assert property (p_index_rd)
        else $error("index read not low nibble");
    property p_mode0_sr;
        @(posedge ref_clk) disable iff (!rstN)
        (memWr && cfg.wmode == pgrw_pkg::PGRW_WM_SUBST &&
            cfg.srEnable[0] == 1'b1 && cfg.func == pgrw_pkg::PGRW_FN_PASS &&
            bitMask_q == 8'hff)
            |=> (planeWdata_q[7:0] == {8{$past(srValue_q[0])}});
    endproperty
    a_mode0_sr: assert property (p_mode0_sr)
        else $error("mode 0 plane 0 not set/reset value");
    property p_mode2_and;
        @(posedge ref_clk) disable iff (!rstN)
        (memWr && cfg.wmode == pgrw_pkg::PGRW_WM_SPREAD &&
            cfg.func == pgrw_pkg::PGRW_FN_AND && bitMask_q == 8'hff)
            |=> (planeWdata_q[7:0] ==
                ({8{$past(memWdata[0])}} & $past(latch_q[7:0])));
    endproperty
    a_mode2_and: assert property (p_mode2_and)
        else $error("mode 2 logic op not applied");
    property p_chain4;
        @(posedge ref_clk) disable iff (!rstN)
        (memRd && !mode_q[`PGRW_MODE_READTYPE] && chain4 &&
            memAddrLow == 2'h1)
            |=> (memRdata_q == $past(planeRdata[15:8]));
    endproperty
    a_chain4: assert property (p_chain4)
        else $error("chain-four read ignored address");
endmodule

// *** pgrw_defines.svh ***
// offsets, field positions and reset values for the graphics datapath
// assumes inclusion by bare name from design files
`ifndef PGRW_DEFINES_SVH
`define PGRW_DEFINES_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define PGRW_IDX_SR_VALUE 4'h0
`define PGRW_IDX_SR_ENABLE 4'h1
`define PGRW_IDX_CMP_VALUE 4'h2
`define PGRW_IDX_ROT_LOGIC 4'h3
`define PGRW_IDX_READ_PLANE 4'h4
`define PGRW_IDX_MODE 4'h5
`define PGRW_IDX_BIT_MASK 4'h8
// ----------------------------------------
// field positions
// ----------------------------------------
`define PGRW_ROT_LSB 0
`define PGRW_FUNC_LSB 3
`define PGRW_MODE_WM_LSB 0
`define PGRW_MODE_READTYPE 3
`define PGRW_MODE_ODDEVEN 4
`define PGRW_MODE_INTERLEAVE 5
`define PGRW_MODE_COLOR256 6
// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define PGRW_RST_REG 8'h00
`define PGRW_RST_MASK 8'hff
`define PGRW_MASK_LOW4 8'h0f
`define PGRW_MASK_ROT 8'h1f
`define PGRW_MASK_PLANE 8'h03
`define PGRW_MASK_MODE 8'h7b
`endif

// *** pgrw_pkg.sv ***
// types shared by the graphics datapath modules
// assumes no other package
package pgrw_pkg;
    typedef enum logic [1:0]
    {
        PGRW_WM_SUBST = 2'b00,
        PGRW_WM_LATCH = 2'b01,
        PGRW_WM_SPREAD = 2'b10,
        PGRW_WM_MASKED = 2'b11
    } pgrw_wmode_e;
    typedef enum logic [1:0]
    {
        PGRW_FN_PASS = 2'b00,
        PGRW_FN_AND = 2'b01,
        PGRW_FN_OR = 2'b10,
        PGRW_FN_XOR = 2'b11
    } pgrw_func_e;
    typedef logic [31:0] pgrw_planes_t;
endpackage

// *** pgrw_cfg_if.sv ***
// configuration fields carried from register file to datapath
// assumes one clock domain
`timescale 1ns/1ps
interface pgrw_cfg_if;
    logic [3:0] srValue;
    logic [3:0] srEnable;
    logic [3:0] cmpValue;
    logic [2:0] rotCount;
    pgrw_pkg::pgrw_func_e func;
    pgrw_pkg::pgrw_wmode_e wmode;
    logic [7:0] bitMask;
    modport regs (output srValue, srEnable, cmpValue, rotCount, func, wmode,
        bitMask);
    modport dp (input srValue, srEnable, cmpValue, rotCount, func, wmode,
        bitMask);
endinterface

// *** pgrw_write_path.sv ***
// combinational write datapath: rotate, substitute, logic op, mask
// assumes latches and config come from the top module
`timescale 1ns/1ps
module pgrw_write_path
(
    // configuration
    pgrw_cfg_if.dp cfg,
    // data
    input wire logic [7:0] hostData,
    input wire pgrw_pkg::pgrw_planes_t latches,
    output logic [31:0] planeOut
);
    function automatic logic [7:0] rotr(input logic [7:0] v,
        input logic [2:0] n);
        logic [15:0] w;
        w = {v, v} >> n;
        return w[7:0];
    endfunction
    function automatic logic [7:0] logicOp(input logic [7:0] d,
        input logic [7:0] l, input pgrw_pkg::pgrw_func_e f);
        logicOp = d;
        unique case (f)
            pgrw_pkg::PGRW_FN_PASS: logicOp = d;
            pgrw_pkg::PGRW_FN_AND: logicOp = d & l;
            pgrw_pkg::PGRW_FN_OR: logicOp = d | l;
            pgrw_pkg::PGRW_FN_XOR: logicOp = d ^ l;
        endcase
    endfunction
    wire logic [7:0] rotated = rotr(hostData, cfg.rotCount);
    // mode 3 mask is rotated data gated by the bit mask
    wire logic [7:0] effMask = (cfg.wmode == pgrw_pkg::PGRW_WM_MASKED) ?
        (rotated & cfg.bitMask) : cfg.bitMask;
    genvar p;
    generate
        for (p = 0; p < 4; p++)
        begin : g_plane
            wire logic [7:0] lat = latches[8*p +: 8];
            wire logic [7:0] srByte = {8{cfg.srValue[p]}};
            wire logic [7:0] src =
                (cfg.wmode == pgrw_pkg::PGRW_WM_SUBST) ?
                    (cfg.srEnable[p] ? srByte : rotated) :
                (cfg.wmode == pgrw_pkg::PGRW_WM_SPREAD) ?
                    {8{hostData[p]}} : srByte;
            // rotation precedes the logic op
            wire logic [7:0] opd = logicOp(src, lat, cfg.func);
            wire logic [7:0] fin =
                (cfg.wmode == pgrw_pkg::PGRW_WM_LATCH) ? lat :
                ((opd & effMask) | (lat & ~effMask));
            assign planeOut[8*p +: 8] = fin;
        end
    endgenerate
endmodule

// *** pgrw_read_path.sv ***
// combinational read datapath: plane select or colour compare
// assumes planes carries the live four plane bytes of the current read, not the latches
`timescale 1ns/1ps
module pgrw_read_path
(
    // configuration
    pgrw_cfg_if.dp cfg,
    // mode
    input wire logic readType,
    input wire logic chain4,
    input wire logic [1:0] planeSel,
    input wire logic [1:0] addrLow,
    // data
    input wire logic [31:0] planes,
    output logic [7:0] readData
);
    logic [7:0] match;
    always_comb
    begin
        match = 8'hff;
        for (int i = 0; i < 4; i++)
            match = match & ~(planes[8*i +: 8] ^ {8{cfg.cmpValue[i]}});
    end
    // chain-four picks the plane from the address, not the field
    wire logic [1:0] sel = chain4 ? addrLow : planeSel;
    wire logic [7:0] mapByte = planes[8*sel +: 8];
    assign readData = readType ? match : mapByte;
endmodule

// *** pgrw_plane_mem.sv ***
// stand-in for the four plane memories: one four-plane word
// assumes the datapath clock; the bench may preload the word
`timescale 1ns/1ps
module pgrw_plane_mem
(
    // clock
    input wire logic ref_clk,
    // datapath side
    input wire logic planeWrite,
    input wire logic [31:0] planeWdata,
    output logic [31:0] planeRdata,
    // bench preload
    input wire logic loadEn,
    input wire logic [31:0] loadData
);
    logic [31:0] word_q;
    // always driven, so data is valid in the cycle of a read
    assign planeRdata = word_q;
    always_ff @(posedge ref_clk)
    begin
        if (loadEn)
            word_q <= loadData;
        else if (planeWrite)
            word_q <= planeWdata;
    end
endmodule

// *** planar_graphics_rw_datapath_bench.sv ***
// self-checking bench for the graphics read/write datapath
// assumes pgrw_top and the plane memory stand-in; inputs move at negedge
`timescale 1ns/1ps
module planar_graphics_rw_datapath_bench;
    logic ref_clk = 1'b0, reset_n = 1'b0;
    logic ioWrIndex = 0, ioWrData = 0, ioRdIndex = 0, ioRdData = 0;
    logic memWr = 0, memRd = 0, chain4 = 0, loadEn = 0;
    logic [1:0] memAddrLow = 2'h0;
    logic [7:0] ioWdata = 8'h00, memWdata = 8'h00, ioRdata_q, memRdata_q;
    logic [31:0] planeRdata, planeWdata_q, loadData = 32'h0;
    logic planeWrite_q, shiftColor256_q, shiftInterleave_q, oddEvenAddr_q;
    logic [7:0] sReg [0:15];
    logic [31:0] seed = 32'h5f724741;
    int n_errors = 0, compares = 0;
    pgrw_top pgrw_top_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .ioWrIndex(ioWrIndex), .ioWrData(ioWrData), .ioRdIndex(ioRdIndex),
        .ioRdData(ioRdData), .ioWdata(ioWdata), .ioRdata_q(ioRdata_q),
        .memWr(memWr), .memRd(memRd), .memAddrLow(memAddrLow),
        .memWdata(memWdata), .memRdata_q(memRdata_q),
        .planeRdata(planeRdata), .planeWdata_q(planeWdata_q),
        .planeWrite_q(planeWrite_q), .chain4(chain4),
        .shiftColor256_q(shiftColor256_q),
        .shiftInterleave_q(shiftInterleave_q),
        .oddEvenAddr_q(oddEvenAddr_q));
    pgrw_plane_mem pgrw_plane_mem_i (.ref_clk(ref_clk),
        .planeWrite(planeWrite_q), .planeWdata(planeWdata_q),
        .planeRdata(planeRdata), .loadEn(loadEn), .loadData(loadData));
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = (seed >> 1) ^ (seed[0] ? 32'h80200003 : 32'h0);
        return seed;
    endfunction
    // writable bits per index; unmapped indices hold nothing
    function automatic logic [7:0] msk(input logic [3:0] i);
        case (i)
            4'h0, 4'h1, 4'h2: return 8'h0f;
            4'h3: return 8'h1f;
            4'h4: return 8'h03;
            4'h5: return 8'h7b;
            4'h8: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [31:0] exp_wr(input logic [7:0] d,
        input logic [31:0] lat);
        logic [7:0] r, s, f, l, m;
        logic [31:0] o;
        logic [2:0] rc;
        rc = sReg[3][2:0];
        r = (d >> rc) | (d << (4'd8 - rc));
        for (int n = 0; n < 4; n++)
        begin
            l = lat[8*n+:8];
            case (sReg[5][1:0])
                2'h0: s = sReg[1][n] ? {8{sReg[0][n]}} : r;
                2'h2: s = {8{d[n]}};
                default: s = {8{sReg[0][n]}};
            endcase
            case (sReg[3][4:3])
                2'h0: f = s;
                2'h1: f = s & l;
                2'h2: f = s | l;
                default: f = s ^ l;
            endcase
            m = (sReg[5][1:0] == 2'h3) ? (r & sReg[8]) : sReg[8];
            o[8*n+:8] = (sReg[5][1:0] == 2'h1) ? l : ((f & m) | (l & ~m));
        end
        return o;
    endfunction
    function automatic logic [7:0] exp_rd(input logic [31:0] lat,
        input logic c4, input logic [1:0] al);
        logic [7:0] r;
        logic [1:0] p;
        p = c4 ? al : sReg[4][1:0];
        r = lat[8*p+:8];
        if (sReg[5][3])
        begin
            for (int b = 0; b < 8; b++)
            begin
                r[b] = 1'b1;
                for (int n = 0; n < 4; n++)
                    if (lat[8*n+b] != sReg[2][n])
                        r[b] = 1'b0;
            end
        end
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // ----------------------------------------
    // host cycles
    // ----------------------------------------
    task automatic io_wr(input logic [3:0] i, input logic [7:0] v);
        @(negedge ref_clk);
        ioWrIndex = 1;
        ioWdata = {4'h0, i};
        @(negedge ref_clk);
        ioWrIndex = 0;
        ioWrData = 1;
        ioWdata = v;
        @(negedge ref_clk);
        ioWrData = 0;
        sReg[i] = v & msk(i);
    endtask
    task automatic io_rd(input logic [3:0] i, output logic [7:0] v);
        @(negedge ref_clk);
        ioWrIndex = 1;
        ioWdata = {4'hf, i};
        @(negedge ref_clk);
        ioWrIndex = 0;
        ioRdData = 1;
        @(negedge ref_clk);
        ioRdData = 0;
        v = ioRdata_q;
    endtask
    // preload planes, read (loads latches), then write back to back
    task automatic mem_cycle(input logic [31:0] pl, input logic [7:0] d,
        input logic c4, input logic [1:0] al);
        @(negedge ref_clk);
        loadEn = 1;
        loadData = pl;
        @(negedge ref_clk);
        loadEn = 0;
        memRd = 1;
        chain4 = c4;
        memAddrLow = al;
        @(negedge ref_clk);
        memRd = 0;
        memWr = 1;
        memWdata = d;
        chk(memRdata_q, exp_rd(pl, c4, al), "read");
        @(negedge ref_clk);
        memWr = 0;
        chk(planeWdata_q, exp_wr(d, pl), "write");
        chk(planeWrite_q, 1'b1, "strobe");
        @(negedge ref_clk);
        chk(planeWrite_q, 1'b0, "strobe end");
        chk(shiftColor256_q, sReg[5][6], "color256");
        chk(shiftInterleave_q, sReg[5][5] & ~sReg[5][6], "ilv");
        chk(oddEvenAddr_q, sReg[5][4], "oddeven");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] v;
        static logic [3:0] idx [9] = '{0, 1, 2, 3, 4, 5, 8, 9, 15};
        for (int i = 0; i < 16; i++)
            sReg[i] = (i == 8) ? 8'hff : 8'h00;
        repeat (8) @(negedge ref_clk);
        reset_n = 1;
        repeat (3) @(negedge ref_clk);
        // reset values, reserved bits, unmapped indices
        foreach (idx[k])
        begin
            io_rd(idx[k], v);
            chk(v, sReg[idx[k]], "reset value");
            io_wr(idx[k], 8'hff);
            io_rd(idx[k], v);
            chk(v, sReg[idx[k]], "masked value");
        end
        @(negedge ref_clk);
        ioRdIndex = 1;
        @(negedge ref_clk);
        ioRdIndex = 0;
        chk(ioRdata_q, 8'h0f, "index read");
        $display("test registers done");
        io_wr(4'h5, 8'h00);
        // every write mode against every function
        for (int w = 0; w < 4; w++)
            for (int f = 0; f < 4; f++)
            begin
                io_wr(4'h0, 8'h05);
                io_wr(4'h1, 8'h03);
                io_wr(4'h3, {3'h0, f[1:0], 3'h3});
                io_wr(4'h5, w[7:0]);
                io_wr(4'h8, 8'h3c);
                mem_cycle(32'h96c35a0f, 8'hb1, 1'b0, 2'h0);
            end
        $display("test mode corners done");
        // directed cases that reach every guarded corner of the read and write paths
        io_wr(4'h1, 8'h05);
        io_wr(4'h2, 8'h00);
        io_wr(4'h4, 8'h02);
        for (int w = 0; w < 4; w++)
            for (int f = 0; f < 4; f++)
            begin
                io_wr(4'h3, {3'h0, f[1:0], 2'h0, w == 0});
                io_wr(4'h5, {4'h0, f[0], 1'b0, w[1:0]});
                io_wr(4'h8, (w == 0 && f == 2) ? 8'h00 : 8'hff);
                mem_cycle(rnd(), (w == 3) ? 8'hff : 8'hb1, f[1], 2'h1);
            end
        $display("test directed done");
        // random register settings and data
        for (int t = 0; t < 150; t++)
        begin
            for (int i = 0; i < 6; i++)
                io_wr(i[3:0], 8'(rnd()));
            io_wr(4'h8, 8'(rnd()));
            v = 8'(rnd());
            mem_cycle(rnd(), v, v[0], v[2:1]);
        end
        $display("test random done");
        wrap_up();
    end
    initial
    begin
        #400000;
        n_errors++;
        $display("[FAIL] %0t run did not finish", $time);
        wrap_up();
    end
endmodule
